// [scc_defs.svh]
// Purpose: Offsets, field positions, reset values of the card contacts
// Assumes: Eight-bit special function register space of the core
// Notes:   Definitions only
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// Register addresses, valid with register page zero
`define SCC_CONTACT_ADDR     8'hAC
`define SCC_STATUS_ADDR      8'hAD
`define SCC_PAGE_VISIBLE     1'b0

// Contact control register fields
`define SCC_CLK_SEL_BIT      7
`define SCC_RSVD_BIT         6
`define SCC_AUX_A_BIT        5
`define SCC_AUX_B_BIT        4
`define SCC_IO_BIT           3
`define SCC_SOFT_CLK_BIT     2
`define SCC_RESET_BIT        1
`define SCC_POWER_BIT        0
`define SCC_CONTACT_RESET    8'h00

// Interface status register fields
`define SCC_ST_TBE_BIT       7
`define SCC_ST_PRESENT_BIT   6
`define SCC_ST_OVERCUR_BIT   5
`define SCC_ST_VGOOD_BIT     4
`define SCC_ST_WTO_BIT       3
`define SCC_ST_SENT_BIT      2
`define SCC_ST_RECV_BIT      1
`define SCC_ST_PARITY_BIT    0
`define SCC_STATUS_RESET     8'h80

`endif

// [scc_pkg.sv]
// Purpose: Types shared by the card contact control block
// Assumes: One clock domain
// Notes:   Constants live in scc_defs.svh
package scc_pkg;

    typedef logic [7:0] scc_byte_t;

    // Card clock switchover sequencer
    typedef enum logic [1:0] {
        SCC_SW_STEADY = 2'b01,
        SCC_SW_WAIT   = 2'b10
    } scc_switch_e;

endpackage : scc_pkg

// [scc_contact_ctrl.sv]
// Purpose: Card contact control register and contact pin drivers
// Assumes: Core clock domain; pins and analog flags are asynchronous
// Notes:   Open-drain contacts need an external pull-up to card VCC
`include "scc_defs.svh"

module scc_contact_ctrl
    import scc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic       register_page_select,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_hit,
    // Card clock sources
    input  wire logic       card_clock_source,
    // UART side
    input  wire logic       uart_select,
    input  wire logic       uart_io_out,
    input  wire logic       tx_buffer_empty_flag,
    input  wire logic       wait_timeout_flag,
    input  wire logic       char_sent_flag,
    input  wire logic       char_received_flag,
    input  wire logic       parity_error_flag,
    // Analog and detect flags
    input  wire logic       card_present_flag,
    input  wire logic       card_overcurrent_flag,
    input  wire logic       card_voltage_good_flag,
    // Card contacts
    output logic            card_power_on,
    output logic            card_reset_pin,
    output logic            card_clock_pin,
    output logic            card_io_pin_out,
    output logic            card_io_pin_oe,
    input  wire logic       card_io_pin_in,
    output logic            aux_contact_a_pin_out,
    output logic            aux_contact_a_pin_oe,
    input  wire logic       aux_contact_a_pin_in,
    output logic            aux_contact_b_pin_out,
    output logic            aux_contact_b_pin_oe,
    input  wire logic       aux_contact_b_pin_in
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic [6:0] raw_in;

    assign raw_in = {card_clock_source, card_io_pin_in,
                     card_present_flag, card_overcurrent_flag,
                     card_voltage_good_flag, aux_contact_a_pin_in,
                     aux_contact_b_pin_in};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    logic iso_clk_s;
    logic io_pin_s;
    logic present_s;
    logic overcur_s;
    logic vgood_s;
    logic aux_a_s;
    logic aux_b_s;

    assign iso_clk_s = sync_b[6];
    assign io_pin_s  = sync_b[5];
    assign present_s = sync_b[4];
    assign overcur_s = sync_b[3];
    assign vgood_s   = sync_b[2];
    assign aux_a_s   = sync_b[1];
    assign aux_b_s   = sync_b[0];

    ////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic logic sel_reg(input logic [7:0] a,
                                     input logic [7:0] target,
                                     input logic       page);
        sel_reg = (a == target) && (page == `SCC_PAGE_VISIBLE);
    endfunction : sel_reg

    logic hit_contact;
    logic hit_status;

    assign hit_contact = sel_reg(sfr_addr, `SCC_CONTACT_ADDR,
                                 register_page_select);
    assign hit_status  = sel_reg(sfr_addr, `SCC_STATUS_ADDR,
                                 register_page_select);
    assign sfr_hit     = (sfr_wr | sfr_rd) & (hit_contact | hit_status);

    ////////////////////////////////////////////////////////////////////
    // Contact control register

    scc_byte_t contact_control_reg;
    scc_byte_t next_contact;

    always_comb begin
        next_contact = contact_control_reg;
        if (sfr_wr && hit_contact) begin
            next_contact = sfr_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            contact_control_reg <= `SCC_CONTACT_RESET;
        end else begin
            contact_control_reg <= next_contact;
        end
    end

    logic pwr;
    logic clk_sel_req;

    assign pwr         = next_contact[`SCC_POWER_BIT];
    assign clk_sel_req = next_contact[`SCC_CLK_SEL_BIT];

    ////////////////////////////////////////////////////////////////////
    // Card clock switchover

    scc_switch_e sw_state;
    scc_switch_e next_sw_state;
    logic        active_sel;
    logic        next_active_sel;
    logic        clk_pin;
    logic        next_clk_pin;

    always_comb begin
        next_sw_state   = sw_state;
        next_active_sel = active_sel;
        unique case (sw_state)
            SCC_SW_STEADY: begin
                if (clk_sel_req != active_sel) begin
                    next_sw_state = SCC_SW_WAIT;
                end
            end
            SCC_SW_WAIT: begin
                if (clk_sel_req == active_sel) begin
                    next_sw_state = SCC_SW_STEADY;
                    // Soft level is static, a high one may end here
                end else if ((!clk_pin || !active_sel) && !iso_clk_s) begin
                    next_active_sel = clk_sel_req;
                    next_sw_state   = SCC_SW_STEADY;
                end
            end
            default: begin
                next_sw_state = SCC_SW_STEADY;
            end
        endcase
    end

    always_comb begin
        if (next_active_sel) begin
            next_clk_pin = iso_clk_s;
        end else begin
            next_clk_pin = next_contact[`SCC_SOFT_CLK_BIT];
        end
        if (next_sw_state == SCC_SW_WAIT && clk_pin == 1'b0) begin
            next_clk_pin = 1'b0;
        end
        if (!pwr) begin
            next_clk_pin = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sw_state   <= SCC_SW_STEADY;
            active_sel <= 1'b0;
            clk_pin    <= 1'b0;
        end else begin
            sw_state   <= next_sw_state;
            active_sel <= next_active_sel;
            clk_pin    <= next_clk_pin;
        end
    end

    assign card_clock_pin = clk_pin;

    ////////////////////////////////////////////////////////////////////
    // Contact pin drivers

    logic next_power;
    logic next_rst;
    logic next_io_low;
    logic next_a_low;
    logic next_b_low;
    logic io_level;

    always_comb begin
        io_level = uart_select ? uart_io_out
                               : next_contact[`SCC_IO_BIT];
        next_power = pwr;
        next_rst   = pwr & next_contact[`SCC_RESET_BIT];
        next_io_low = ~io_level;
        next_a_low  = ~next_contact[`SCC_AUX_A_BIT];
        next_b_low  = ~next_contact[`SCC_AUX_B_BIT];
        if (!pwr) begin
            next_io_low = 1'b1;
            next_a_low  = 1'b1;
            next_b_low  = 1'b1;
        end
    end

    logic power_q;
    logic rst_q;
    logic io_low_q;
    logic a_low_q;
    logic b_low_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            power_q  <= 1'b0;
            rst_q    <= 1'b0;
            io_low_q <= 1'b1;
            a_low_q  <= 1'b1;
            b_low_q  <= 1'b1;
        end else begin
            power_q  <= next_power;
            rst_q    <= next_rst;
            io_low_q <= next_io_low;
            a_low_q  <= next_a_low;
            b_low_q  <= next_b_low;
        end
    end

    assign card_power_on         = power_q;
    assign card_reset_pin        = rst_q;
    assign card_io_pin_out       = 1'b0;
    assign card_io_pin_oe        = io_low_q;
    assign aux_contact_a_pin_out = 1'b0;
    assign aux_contact_a_pin_oe  = a_low_q;
    assign aux_contact_b_pin_out = 1'b0;
    assign aux_contact_b_pin_oe  = b_low_q;

    ////////////////////////////////////////////////////////////////////
    // Read data

    scc_byte_t status_view;
    scc_byte_t contact_view;
    scc_byte_t next_rdata;
    scc_byte_t rdata_q;

    always_comb begin
        status_view = `SCC_STATUS_RESET;
        status_view[`SCC_ST_TBE_BIT]     = tx_buffer_empty_flag;
        status_view[`SCC_ST_PRESENT_BIT] = present_s;
        status_view[`SCC_ST_OVERCUR_BIT] = overcur_s;
        status_view[`SCC_ST_VGOOD_BIT]   = vgood_s;
        status_view[`SCC_ST_WTO_BIT]     = wait_timeout_flag;
        status_view[`SCC_ST_SENT_BIT]    = char_sent_flag;
        status_view[`SCC_ST_RECV_BIT]    = char_received_flag;
        status_view[`SCC_ST_PARITY_BIT]  = parity_error_flag;
        contact_view = contact_control_reg;
        contact_view[`SCC_IO_BIT] = io_pin_s;
        // Aux contacts read back their pins as well
        contact_view[`SCC_AUX_A_BIT] =
            contact_control_reg[`SCC_AUX_A_BIT] & aux_a_s;
        contact_view[`SCC_AUX_B_BIT] =
            contact_control_reg[`SCC_AUX_B_BIT] & aux_b_s;
        next_rdata = 8'h00;
        if (sfr_rd && hit_contact) begin
            next_rdata = contact_view;
        end else if (sfr_rd && hit_status) begin
            next_rdata = status_view;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= next_rdata;
        end
    end

    assign sfr_rdata = rdata_q;

endmodule : scc_contact_ctrl

// [scc_contact_ctrl_checker.sv]
// Purpose: Port checks for the card contact block
// Assumes: Single core clock, async active-low reset
// Notes:   Bound to every scc_contact_ctrl instance
module scc_contact_ctrl_checker (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic       register_page_select,
    input  wire logic       uart_select,
    input  wire logic [7:0] sfr_rdata,
    input  wire logic       sfr_hit,
    input  wire logic       card_power_on,
    input  wire logic       card_reset_pin,
    input  wire logic       card_clock_pin,
    input  wire logic       card_io_pin_oe,
    input  wire logic       aux_contact_a_pin_oe,
    input  wire logic       aux_contact_b_pin_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic wr_c;
    logic sel_w;
    assign wr_c = sfr_wr && sfr_addr == 8'hAC && !register_page_select;
    // Last written clock select, a pending switch delays the pin
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) sel_w <= 1'b0;
        else if (wr_c) sel_w <= sfr_wdata[7];
    end
    sequence s_wr_on;
        wr_c && sfr_wdata[0];
    endsequence
    property p_power;
        wr_c |=> card_power_on == $past(sfr_wdata[0]);
    endproperty
    a_power: assert property (p_power)
        else $error("power pin wrong");
    property p_rst;
        wr_c |=> card_reset_pin == $past(sfr_wdata[1] & sfr_wdata[0]);
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset pin wrong");
    property p_auxa;
        wr_c |=> aux_contact_a_pin_oe == !$past(sfr_wdata[5] & sfr_wdata[0]);
    endproperty
    a_auxa: assert property (p_auxa)
        else $error("aux a drive wrong");
    property p_auxb;
        wr_c |=> aux_contact_b_pin_oe == !$past(sfr_wdata[4] & sfr_wdata[0]);
    endproperty
    a_auxb: assert property (p_auxb)
        else $error("aux b drive wrong");
    property p_io;
        wr_c && !uart_select |=>
            card_io_pin_oe == !$past(sfr_wdata[3] & sfr_wdata[0]);
    endproperty
    a_io: assert property (p_io)
        else $error("io drive wrong");
    property p_soft;
        s_wr_on ##0 (!sfr_wdata[7] && !sel_w) |=>
            card_clock_pin == $past(sfr_wdata[2]);
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft clock level wrong");
    property p_off;
        !card_power_on |-> !card_reset_pin && !card_clock_pin &&
            card_io_pin_oe && aux_contact_a_pin_oe && aux_contact_b_pin_oe;
    endproperty
    a_off: assert property (p_off)
        else $error("contacts active with power off");
    property p_miss;
        sfr_rd && (register_page_select || sfr_addr[7:1] != 7'h56) |=>
            sfr_rdata == 8'h00;
    endproperty
    a_miss: assert property (p_miss)
        else $error("unmapped read returned data");
    property p_hit;
        sfr_hit == ((sfr_wr || sfr_rd) && sfr_addr[7:1] == 7'h56 &&
            !register_page_select);
    endproperty
    a_hit: assert property (p_hit)
        else $error("register hit flag wrong");
endmodule : scc_contact_ctrl_checker

bind scc_contact_ctrl scc_contact_ctrl_checker u_chk (.clk, .resetn,
    .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .register_page_select,
    .uart_select, .sfr_rdata, .sfr_hit, .card_power_on, .card_reset_pin,
    .card_clock_pin, .card_io_pin_oe, .aux_contact_a_pin_oe,
    .aux_contact_b_pin_oe);

// [scc_card_model.sv]
// Purpose: Inserted card as seen at the contact pins
// Assumes: Pull-ups to card supply, so unpowered lines read low
// Notes:   pull inputs make the card hold a line low
module scc_card_model (
    input  wire logic powered,
    input  wire logic io_oe,
    input  wire logic a_oe,
    input  wire logic b_oe,
    input  wire logic io_out,
    input  wire logic a_out,
    input  wire logic b_out,
    input  wire logic pull_io,
    input  wire logic pull_a,
    input  wire logic pull_b,
    output logic      io_level,
    output logic      a_level,
    output logic      b_level
);
    assign io_level = powered && (io_oe ? io_out : !pull_io);
    assign a_level = powered && (a_oe ? a_out : !pull_a);
    assign b_level = powered && (b_oe ? b_out : !pull_b);
endmodule : scc_card_model

// [tb_top.sv]
// Purpose: Self-checking bench for the card contact block
// Assumes: 40 MHz core clock, card lines through the model
// Notes:   Card clock source toggles every 4 core cycles
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import scc_pkg::*;
    logic       clk, resetn, wr, rd, pg, usel, uio, src, pio, pa, pb;
    logic [7:0] addr, wdata, rdata, flg, pins;
    logic [1:0] cnt;
    logic [2:0] hist;
    logic       pwr, rstp, clkp, io_oe, a_oe, b_oe, io_in, a_in, b_in;
    logic       hit, hit_seen, io_o, a_o, b_o;
    int         n_errors, n_compared, run, runt;
    scc_byte_t  v;
    assign pins = {2'b00, pwr, rstp, clkp, io_oe, a_oe, b_oe};
    scc_contact_ctrl dut (.clk(clk), .resetn(resetn), .sfr_addr(addr),
        .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd),
        .register_page_select(pg), .sfr_rdata(rdata), .sfr_hit(hit),
        .card_clock_source(src), .uart_select(usel), .uart_io_out(uio),
        .tx_buffer_empty_flag(flg[7]), .card_present_flag(flg[6]),
        .card_overcurrent_flag(flg[5]), .card_voltage_good_flag(flg[4]),
        .wait_timeout_flag(flg[3]), .char_sent_flag(flg[2]),
        .char_received_flag(flg[1]), .parity_error_flag(flg[0]),
        .card_power_on(pwr), .card_reset_pin(rstp), .card_clock_pin(clkp),
        .card_io_pin_out(io_o), .card_io_pin_oe(io_oe),
        .card_io_pin_in(io_in),
        .aux_contact_a_pin_out(a_o), .aux_contact_a_pin_oe(a_oe),
        .aux_contact_a_pin_in(a_in), .aux_contact_b_pin_out(b_o),
        .aux_contact_b_pin_oe(b_oe), .aux_contact_b_pin_in(b_in));
    scc_card_model card (.powered(pwr), .io_oe(io_oe), .a_oe(a_oe),
        .b_oe(b_oe), .io_out(io_o), .a_out(a_o), .b_out(b_o),
        .pull_io(pio), .pull_a(pa), .pull_b(pb),
        .io_level(io_in), .a_level(a_in), .b_level(b_in));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cnt <= cnt + 2'd1;
        hist <= {hist[1:0], src};
        if (cnt == 2'd3) src <= ~src;
    end
    // Short high pulses on the card clock are runts
    always @(negedge clk) begin
        if (clkp) run = run + 1;
        else begin
            if (run != 0 && run < 4) runt = runt + 1;
            run = 0;
        end
    end
    task automatic check(input scc_byte_t seen, input scc_byte_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input scc_byte_t a, input scc_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input scc_byte_t a, output scc_byte_t d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        #1 hit_seen = hit;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic t_basic();
        @(negedge clk);
        check(pins, 8'h07);
        rd_reg(8'hAC, v);
        check(v & 8'hBF, 8'h00);
        check({7'b0, hit_seen}, 8'h01);
        wr_reg(8'hAC, 8'h3E);
        check(pins, 8'h07);
        wr_reg(8'hAC, 8'h3F);
        check(pins, 8'h38);
        repeat (4) @(posedge clk);
        rd_reg(8'hAC, v);
        check(v & 8'hBF, 8'h3F);
        @(posedge clk);
        pio <= 1'b1;
        pa <= 1'b1;
        pb <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(8'hAC, v);
        check(v & 8'hBF, 8'h07);
        @(posedge clk);
        pio <= 1'b0;
        pa <= 1'b0;
        pb <= 1'b0;
        wr_reg(8'hAC, 8'h01);
        check(pins, 8'h27);
    endtask : t_basic
    task automatic t_page_uart();
        @(posedge clk);
        pg <= 1'b1;
        wr_reg(8'hAC, 8'h00);
        check(pins, 8'h27);
        rd_reg(8'hAC, v);
        check(v, 8'h00);
        check({7'b0, hit_seen}, 8'h00);
        @(posedge clk);
        pg <= 1'b0;
        rd_reg(8'hAE, v);
        check(v, 8'h00);
        check({7'b0, hit_seen}, 8'h00);
        wr_reg(8'hAC, 8'h09);
        @(posedge clk);
        usel <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check({7'b0, io_oe}, 8'h01);
        @(posedge clk);
        uio <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check({7'b0, io_oe}, 8'h00);
        @(posedge clk);
        usel <= 1'b0;
        wr_reg(8'hAC, 8'h01);
        check({7'b0, io_oe}, 8'h01);
    endtask : t_page_uart
    task automatic t_clock_status();
        scc_byte_t pat [2];
        pat = '{8'h5A, 8'hA5};
        wr_reg(8'hAC, 8'h81);
        repeat (8) @(posedge clk);
        repeat (12) begin
            @(posedge clk);
            #1 check({7'b0, clkp}, {7'b0, hist[2]});
        end
        wr_reg(8'hAC, 8'h05);
        repeat (12) @(posedge clk);
        #1 check({7'b0, clkp}, 8'h01);
        wr_reg(8'hAC, 8'h85);
        repeat (10) @(posedge clk);
        repeat (8) begin
            @(posedge clk);
            #1 check({7'b0, clkp}, {7'b0, hist[2]});
        end
        check(runt[7:0], 8'h00);
        foreach (pat[i]) begin
            @(posedge clk);
            flg <= pat[i];
            repeat (3) @(posedge clk);
            rd_reg(8'hAD, v);
            check(v, pat[i]);
            check({7'b0, hit_seen}, 8'h01);
        end
    endtask : t_clock_status
    task automatic final_report();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        {wr, rd, pg, usel, uio, src, pio, pa, pb, cnt, hist} = '0;
        addr = 8'h00;
        wdata = 8'h00;
        flg = 8'h90;
        n_errors = 0;
        n_compared = 0;
        run = 0;
        runt = 0;
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        // power first, supply good held while contacts move
        t_basic();
        t_page_uart();
        t_clock_status();
        final_report();
    end
    initial begin
        #2_000_000;
        n_errors++;
        final_report();
    end
endmodule : tb_top
